// [dcc_converter_control.sv]
// converter control: a/d sequencing, sample fifo, d/a update, byte registers
`timescale 1ns/100ps
// Behaviour
// - every finished conversion result is pushed into the sample fifo while it has room for two bytes.
// - reading offset 0 or 1 pops one byte; two reads give one sample.
// - irq off, scan off: host trigger bit starts one conversion; busy follows status.
// - irq off, scan on: host trigger converts first through last channel.
// - in scan, busy rises at first status pulse, falls after last one.
// - with irq off the fifo gate bit changes nothing.
// - with irq on and gate bit 0 set, conversions start from the selected trigger source.
// - irq on, gate off, scan off: interrupt after each conversion.
// - irq on, gate off, scan on: interrupt once per scan at wait fall.
// - irq on, gate on, scan off: interrupt when fill reaches threshold.
// - irq on, gate on, scan on: interrupt at scan end with threshold reached.
// - each output channel takes an unsigned 12-bit code 0 to 4095.
// - output range unipolar or bipolar is chosen in the config register.
// - bipolar output code is offset binary, 2048 meaning zero volts.
// - code high register keeps only 4 bits, forming code bits 11-8.
// - select write with hold clear transfers code and updates the output.
// - select write with hold bit 7 set only buffers the code.
// - buffered codes wait so several outputs can change together.
// - next select write with hold clear applies all buffered codes at once.
// - every select write sets dac busy for the transfer time.
// - control register: irq enable bit 4, scan 2, trigger source 1, gate 0.
// - status register: a/d busy at bit 7, scan wait at bit 6.
module dcc_converter_control (
	input logic sys_clk,
	input logic rst_b,
	input logic [3:0] bus_addr,
	input logic bus_wr,
	input logic bus_rd,
	input logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input logic converter_status,
	input logic [15:0] adc_data,
	input logic ext_trigger,
	input logic pacer_tick,
	output logic adc_start,
	output logic [4:0] adc_channel,
	output logic adc_irq,
	output logic [11:0] dac_out [4],
	output logic dac_bipolar,
	output logic [7:0] analog_config
);
	import dcc_pkg::*;

	logic [7:0] fifo_mem [FIFO_BYTES];
	logic [7:0] cfg_q, ctrl_q, code_lo_q, code_hi_q;
	logic [4:0] chan_low_q, chan_high_q, chan_q;
	logic [10:0] thresh_q;
	logic [11:0] wr_ptr_q, rd_ptr_q;
	logic [12:0] byte_cnt_q;
	logic [11:0] fill_samples;
	logic [11:0] fill_next;
	logic hi_pend_q, thresh_flag_q, ovf_q;
	logic [15:0] sample_q;
	logic [1:0] stat_sync_q, ext_sync_q;
	logic [15:0] data_s1_q, data_s2_q;
	logic ext_prev_q;
	logic status_s, ext_edge;
	dcc_seq_e seq_q;
	logic scan_busy_q, scan_wait_q, run_scan_q, start_q, irq_q;
	logic wr_hit, rd_pop, host_trig, src_trig, trig, last_chan;
	logic store_evt, push_ok, done_evt, irq_set, irq_clr, fifo_rst;
	logic irq_en, fifo_gate, scan_en, adc_active;
	logic [11:0] dac_buf_q [4];
	logic [11:0] dac_out_q [4];
	logic [8:0] xfer_cnt_q;
	logic apply_pend_q, dac_xfer;

	// strobes decoded from the byte port
	assign wr_hit = bus_wr;
	assign rd_pop = bus_rd && (bus_addr == OFS_SAMPLE_LO ||
		bus_addr == OFS_SAMPLE_HI_CFG) && byte_cnt_q != 13'h0000;
	assign host_trig = wr_hit && bus_addr == OFS_TRIGGER && bus_wdata[TRIG_START];
	assign fifo_rst = wr_hit && bus_addr == OFS_TRIGGER &&
		bus_wdata[TRIG_FIFO_RST];
	assign irq_clr = wr_hit && bus_addr == OFS_TRIGGER &&
		bus_wdata[TRIG_IRQ_ACK];
	assign irq_en = ctrl_q[CTRL_IRQ_EN];
	assign fifo_gate = ctrl_q[CTRL_FIFO_GATE];
	assign scan_en = ctrl_q[CTRL_SCAN];

	// host writable configuration registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= RESET_BYTE;
			ctrl_q <= RESET_BYTE;
			chan_low_q <= 5'h00;
			chan_high_q <= 5'h00;
			thresh_q <= 11'h000;
			code_lo_q <= RESET_BYTE;
			code_hi_q <= RESET_BYTE;
		end else if (wr_hit) begin
			unique case (bus_addr)
				OFS_SAMPLE_HI_CFG: cfg_q <= bus_wdata;
				OFS_ADC_CTRL: ctrl_q <= bus_wdata;
				OFS_CHAN_LOW: chan_low_q <= bus_wdata[4:0];
				OFS_CHAN_HIGH: chan_high_q <= bus_wdata[4:0];
				OFS_THRESH_LO: thresh_q[7:0] <= bus_wdata;
				OFS_THRESH_HI: thresh_q[10:8] <= bus_wdata[2:0];
				OFS_CODE_LO: code_lo_q <= bus_wdata;
				OFS_CODE_HI: code_hi_q <= {4'h0, bus_wdata[3:0]};
				default: ;
			endcase
		end
	end

	// two-stage synchronisers for converter and trigger pins
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			stat_sync_q <= 2'b00;
			ext_sync_q <= 2'b00;
			ext_prev_q <= 1'b0;
			data_s1_q <= 16'h0000;
			data_s2_q <= 16'h0000;
		end else begin
			stat_sync_q <= {stat_sync_q[0], converter_status};
			ext_sync_q <= {ext_sync_q[0], ext_trigger};
			ext_prev_q <= ext_sync_q[1];
			data_s1_q <= adc_data;
			data_s2_q <= data_s1_q;
		end
	end
	assign status_s = stat_sync_q[1];
	assign ext_edge = ext_sync_q[1] && !ext_prev_q;

	// trigger choice: host write when irq off, selected source gated by bit 0 when on
	assign src_trig = ctrl_q[CTRL_PACER_GATE] &&
		(ctrl_q[CTRL_TRIG_SRC] ? pacer_tick : ext_edge);
	assign trig = irq_en ? src_trig : host_trig;
	assign last_chan = !run_scan_q || chan_q == chan_high_q;
	assign store_evt = seq_q == SEQ_STORE;
	assign done_evt = store_evt && last_chan;

	// conversion sequencer, one channel per pass
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			seq_q <= SEQ_IDLE;
			chan_q <= 5'h00;
			run_scan_q <= 1'b0;
			start_q <= 1'b0;
			sample_q <= 16'h0000;
		end else begin
			start_q <= 1'b0;
			unique case (seq_q)
				SEQ_IDLE: begin
					if (trig) begin
						run_scan_q <= scan_en;
						if (scan_en) begin
							chan_q <= chan_low_q;
						end
						seq_q <= SEQ_START;
					end
				end
				SEQ_START: begin
					start_q <= 1'b1;
					seq_q <= SEQ_HIGHW;
				end
				SEQ_HIGHW: if (status_s) seq_q <= SEQ_LOWW;
				SEQ_LOWW: begin
					if (!status_s) begin
						sample_q <= data_s2_q;
						seq_q <= SEQ_STORE;
					end
				end
				SEQ_STORE: begin
					if (chan_q == chan_high_q) begin
						chan_q <= chan_low_q;
					end else begin
						chan_q <= chan_q + 5'h01;
					end
					seq_q <= last_chan ? SEQ_IDLE : SEQ_START;
				end
			endcase
		end
	end

	// scan busy and scan wait flags
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			scan_busy_q <= 1'b0;
			scan_wait_q <= 1'b0;
		end else begin
			if (done_evt) begin
				scan_busy_q <= 1'b0;
				scan_wait_q <= 1'b0;
			end else begin
				if (run_scan_q && seq_q == SEQ_HIGHW && status_s) begin
					scan_busy_q <= 1'b1;
				end
				if (seq_q == SEQ_IDLE && trig && scan_en) begin
					scan_wait_q <= 1'b1;
				end
			end
		end
	end
	assign adc_active = run_scan_q ? scan_busy_q : status_s;

	// sample fifo: low byte then high byte, count kept in bytes
	assign push_ok = store_evt && byte_cnt_q <= FIFO_LAST_PAIR;
	assign fill_samples = byte_cnt_q[12:1];
	assign fill_next = fill_samples + 12'h001;
	always_ff @(posedge sys_clk) begin
		if (push_ok) begin
			fifo_mem[wr_ptr_q] <= sample_q[7:0];
		end else if (hi_pend_q) begin
			fifo_mem[wr_ptr_q] <= sample_q[15:8];
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_q <= 12'h000;
			rd_ptr_q <= 12'h000;
			byte_cnt_q <= 13'h0000;
			hi_pend_q <= 1'b0;
			ovf_q <= 1'b0;
			thresh_flag_q <= 1'b0;
		end else if (fifo_rst) begin
			wr_ptr_q <= 12'h000;
			rd_ptr_q <= 12'h000;
			byte_cnt_q <= 13'h0000;
			hi_pend_q <= 1'b0;
			ovf_q <= store_evt && !push_ok; // set beats the reset clear
			thresh_flag_q <= push_ok && fill_next >= {1'b0, thresh_q};
		end else begin
			hi_pend_q <= push_ok;
			if (push_ok || hi_pend_q) begin
				wr_ptr_q <= wr_ptr_q + 12'h001;
			end
			if (rd_pop) begin
				rd_ptr_q <= rd_ptr_q + 12'h001;
			end
			if ((push_ok || hi_pend_q) && !rd_pop) begin
				byte_cnt_q <= byte_cnt_q + 13'h0001;
			end else if (!(push_ok || hi_pend_q) && rd_pop) begin
				byte_cnt_q <= byte_cnt_q - 13'h0001;
			end
			if (store_evt && !push_ok) begin
				ovf_q <= 1'b1;
			end
			if (push_ok && fill_next >= {1'b0, thresh_q}) begin
				thresh_flag_q <= 1'b1;
			end
		end
	end

	// interrupt source per mode, set wins over acknowledge
	always_comb begin
		irq_set = 1'b0;
		if (irq_en) begin
			unique case ({fifo_gate, run_scan_q})
				2'b00: irq_set = done_evt;
				2'b01: irq_set = done_evt;
				2'b10: irq_set = push_ok && fill_next >= {1'b0, thresh_q};
				2'b11: irq_set = done_evt && push_ok &&
					fill_next >= {1'b0, thresh_q};
			endcase
		end
	end
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_q <= 1'b0;
		end else if (irq_set) begin
			irq_q <= 1'b1;
		end else if (irq_clr || !irq_en) begin
			irq_q <= 1'b0;
		end
	end

	// d/a select writes: buffer code, time transfer, apply on hold clear
	assign dac_xfer = xfer_cnt_q != 9'h000;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < 4; i++) begin
				dac_buf_q[i] <= 12'h000;
				dac_out_q[i] <= 12'h000;
			end
			xfer_cnt_q <= 9'h000;
			apply_pend_q <= 1'b0;
		end else begin
			if (wr_hit && bus_addr == OFS_OUT_SELECT) begin
				dac_buf_q[bus_wdata[1:0]] <= {code_hi_q[3:0], code_lo_q};
				xfer_cnt_q <= DAC_XFER_CNT;
				apply_pend_q <= !bus_wdata[SEL_HOLD];
			end else if (dac_xfer) begin
				xfer_cnt_q <= xfer_cnt_q - 9'h001;
				if (xfer_cnt_q == 9'h001 && apply_pend_q) begin
					apply_pend_q <= 1'b0;
					for (int i = 0; i < 4; i++) begin
						dac_out_q[i] <= dac_buf_q[i];
					end
				end
			end
		end
	end
	// codes pass unchanged; unipolar straight, bipolar offset binary
	assign dac_out = dac_out_q;
	assign dac_bipolar = cfg_q[CFG_DAC_BIPOLAR];
	assign analog_config = cfg_q;

	// registered read data, fifo byte on either sample offset
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_rdata <= RESET_BYTE;
		end else if (bus_rd) begin
			unique case (bus_addr)
				OFS_SAMPLE_LO, OFS_SAMPLE_HI_CFG:
					bus_rdata <= rd_pop ? fifo_mem[rd_ptr_q] : RESET_BYTE;
				OFS_CHAN_LOW: bus_rdata <= {3'b000, chan_low_q};
				OFS_CHAN_HIGH: bus_rdata <= {3'b000, chan_high_q};
				OFS_STATUS: bus_rdata <= {adc_active, scan_wait_q, dac_xfer,
					chan_q};
				OFS_THRESH_LO: bus_rdata <= thresh_q[7:0];
				OFS_THRESH_HI: bus_rdata <= {5'h00, thresh_q[10:8]};
				OFS_DEPTH_LO: bus_rdata <= fill_samples[7:0];
				OFS_DEPTH_HI: bus_rdata <= {4'h0, fill_samples[11:8]};
				OFS_ADC_CTRL: bus_rdata <= ctrl_q;
				OFS_FLAGS: bus_rdata <= {4'h0, thresh_flag_q, 2'b00, ovf_q};
				default: bus_rdata <= RESET_BYTE;
			endcase
		end
	end

	assign adc_start = start_q;
	assign adc_channel = chan_q;
	assign adc_irq = irq_q;
endmodule : dcc_converter_control

// [dcc_pkg.sv]
// shared constants for the data-acquisition converter control block
package dcc_pkg;
	localparam logic [3:0] OFS_SAMPLE_LO = 4'h0;
	localparam logic [3:0] OFS_SAMPLE_HI_CFG = 4'h1;
	localparam logic [3:0] OFS_CHAN_LOW = 4'h2;
	localparam logic [3:0] OFS_CHAN_HIGH = 4'h3;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_OUT_SELECT = 4'h5;
	localparam logic [3:0] OFS_CODE_LO = 4'h6;
	localparam logic [3:0] OFS_CODE_HI = 4'h7;
	localparam logic [3:0] OFS_THRESH_LO = 4'h8;
	localparam logic [3:0] OFS_THRESH_HI = 4'h9;
	localparam logic [3:0] OFS_DEPTH_LO = 4'ha;
	localparam logic [3:0] OFS_DEPTH_HI = 4'hb;
	localparam logic [3:0] OFS_ADC_CTRL = 4'hd;
	localparam logic [3:0] OFS_FLAGS = 4'he;
	localparam logic [3:0] OFS_TRIGGER = 4'hf;
	// control register bit positions
	localparam int CTRL_PACER_GATE = 0;
	localparam int CTRL_TRIG_SRC = 1;
	localparam int CTRL_SCAN = 2;
	localparam int CTRL_IRQ_EN = 4;
	localparam int CTRL_FIFO_GATE = 5;
	// trigger register bits
	localparam int TRIG_START = 0;
	localparam int TRIG_IRQ_ACK = 1;
	localparam int TRIG_FIFO_RST = 4;
	// config, select, status and flag bits
	localparam int CFG_DAC_BIPOLAR = 2;
	localparam int SEL_HOLD = 7;
	localparam int STS_ADC_ACTIVE = 7;
	localparam int STS_SCAN_WAIT = 6;
	localparam int STS_DAC_XFER = 5;
	localparam int FLG_THRESH = 3;
	localparam int FLG_OVERFLOW = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	// fifo geometry: 2048 samples of two bytes
	localparam int FIFO_BYTES = 4096;
	localparam logic [12:0] FIFO_LAST_PAIR = 13'h0ffe;
	// dac transfer time
	localparam int CLK_MHZ = 10;
	localparam int DAC_XFER_US = 30;
	localparam int DAC_XFER_CYC = DAC_XFER_US * CLK_MHZ;
	localparam logic [8:0] DAC_XFER_CNT = 9'(DAC_XFER_CYC);
	typedef enum logic [4:0] {
		SEQ_IDLE = 5'b00001,
		SEQ_START = 5'b00010,
		SEQ_HIGHW = 5'b00100,
		SEQ_LOWW = 5'b01000,
		SEQ_STORE = 5'b10000
	} dcc_seq_e;
endpackage : dcc_pkg

// [dcc_converter_control_props.sv]
// assertions on the converter control ports
`timescale 1ns/100ps
module dcc_converter_control_props
	import dcc_pkg::*;
(
	input logic sys_clk,
	input logic rst_b,
	input logic [3:0] bus_addr,
	input logic bus_wr,
	input logic bus_rd,
	input logic [7:0] bus_wdata,
	input logic [7:0] bus_rdata,
	input logic converter_status,
	input logic adc_start,
	input logic [4:0] adc_channel,
	input logic adc_irq,
	input logic [11:0] dac_out [4],
	input logic dac_bipolar,
	input logic [7:0] analog_config
);
	logic [8:0] sel_cnt_q;
	logic hold_q;
	logic irq_en_q;
	logic sel_wr;
	logic [47:0] dac_all;
	assign sel_wr = bus_wr && bus_addr == OFS_OUT_SELECT;
	assign dac_all = {dac_out[3], dac_out[2], dac_out[1], dac_out[0]};
	// cycles since the last select write, and its hold bit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_cnt_q <= 9'h1ff;
			hold_q <= 1'b0;
		end else if (sel_wr) begin
			sel_cnt_q <= 9'h000;
			hold_q <= bus_wdata[SEL_HOLD];
		end else if (sel_cnt_q != 9'h1ff) begin
			sel_cnt_q <= sel_cnt_q + 9'h001;
		end
	end
	// mirror of the interrupt enable bit
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_en_q <= 1'b0;
		end else if (bus_wr && bus_addr == OFS_ADC_CTRL) begin
			irq_en_q <= bus_wdata[CTRL_IRQ_EN];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_start_one_cycle: assert property (adc_start |=> !adc_start)
		else $error("start pulse too long");
	a_config_write: assert property (bus_wr && bus_addr == OFS_SAMPLE_HI_CFG
		|=> analog_config == $past(bus_wdata)) else $error("config not taken");
	a_bipolar_follow: assert property (dac_bipolar ==
		analog_config[CFG_DAC_BIPOLAR]) else $error("range bit wrong");
	a_dac_hold_off: assert property (sel_wr |=> $stable(dac_all)[*8])
		else $error("output moved during transfer");
	a_dac_late_apply: assert property ($changed(dac_all) |->
		sel_cnt_q >= 9'h127 && sel_cnt_q <= 9'h136)
		else $error("output applied at wrong time");
	a_hold_no_apply: assert property ($changed(dac_all) |-> !hold_q)
		else $error("held code reached output");
	a_irq_enable: assert property ($rose(adc_irq) |-> irq_en_q)
		else $error("interrupt while disabled");
	a_irq_off_clear: assert property (!irq_en_q |=> !adc_irq)
		else $error("interrupt kept while disabled");
	a_dac_busy_read: assert property (bus_rd && bus_addr == OFS_STATUS &&
		sel_cnt_q < 9'h0fa |=> bus_rdata[STS_DAC_XFER])
		else $error("transfer flag low");
	a_chan_stable: assert property (converter_status |=>
		$stable(adc_channel)) else $error("channel moved in conversion");
endmodule : dcc_converter_control_props

bind dcc_converter_control dcc_converter_control_props u_props (
	.sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.converter_status(converter_status), .adc_start(adc_start),
	.adc_channel(adc_channel), .adc_irq(adc_irq), .dac_out(dac_out),
	.dac_bipolar(dac_bipolar), .analog_config(analog_config)
);

// [dcc_adc_model.sv]
// behavioural a/d converter on the far side of the block
`timescale 1ns/100ps
module dcc_adc_model (
	input logic sys_clk,
	input logic adc_start,
	input logic [15:0] smp_base,
	output logic converter_status,
	output logic [15:0] adc_data
);
	int n;
	// one conversion per start pulse, some prompt and some slow
	initial begin
		converter_status = 1'b0;
		adc_data = 16'h0000;
		n = 0;
		forever begin
			@(posedge sys_clk);
			if (adc_start === 1'b1) begin
				repeat (3) @(posedge sys_clk);
				converter_status <= 1'b1;
				adc_data <= smp_base + 16'(n); // result steady once status low
				n++;
				repeat (4 + n % 4) @(posedge sys_clk);
				converter_status <= 1'b0;
			end
		end
	end
endmodule : dcc_adc_model

// [tb_daq_converter_control.sv]
// random and corner-case bench for the converter control block
`timescale 1ns/100ps
module tb_daq_converter_control;
	import dcc_pkg::*;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] bus_addr = 4'h0;
	logic bus_wr = 1'b0;
	logic bus_rd = 1'b0;
	logic [7:0] bus_wdata = 8'h00;
	logic pacer_tick = 1'b0;
	logic ext_trig = 1'b0;
	logic [15:0] base = 16'h0000;
	logic [7:0] bus_rdata, analog_config, rb;
	logic converter_status, adc_start, adc_irq, dac_bipolar;
	logic [15:0] adc_data;
	logic [4:0] adc_channel;
	logic [11:0] dac_out [4];
	logic [11:0] exp_code [4];
	int err_total = 0;
	int tests_run = 0;
	int seed = 3;
	int cyc = 0;
	int starts = 0;
	int nread = 0;
	int k;
	// clock
	always #50 sys_clk = ~sys_clk;
	dcc_converter_control DUT (.sys_clk(sys_clk), .rst_b(rst_b),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.converter_status(converter_status), .adc_data(adc_data),
		.ext_trigger(ext_trig), .pacer_tick(pacer_tick), .adc_start(adc_start),
		.adc_channel(adc_channel), .adc_irq(adc_irq), .dac_out(dac_out),
		.dac_bipolar(dac_bipolar), .analog_config(analog_config));
	dcc_adc_model u_adc (.sys_clk(sys_clk), .adc_start(adc_start),
		.smp_base(base), .converter_status(converter_status),
		.adc_data(adc_data));
	// start counter and hang limit
	always @(posedge sys_clk) begin
		cyc++;
		if (adc_start === 1'b1) starts++;
		if (cyc == 8000) begin
			err_total++;
			summarize();
		end
	end
	function automatic logic [15:0] exp_smp(input int i);
		return base + 16'(i);
	endfunction : exp_smp
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= 1'b1;
		@(posedge sys_clk);
		bus_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		bus_addr <= a;
		bus_rd <= 1'b1;
		@(posedge sys_clk);
		bus_rd <= 1'b0;
		#1;
		d = bus_rdata;
	endtask : rd
	task automatic rd_chk(input int n);
		logic [7:0] lo, hi;
		for (int i = 0; i < n; i++) begin
			rd(4'(i % 2), lo);
			rd(4'(i % 2), hi);
			chk({hi, lo}, exp_smp(nread));
			nread++;
		end
	endtask : rd_chk
	task automatic wait_idle;
		logic [7:0] s;
		s = 8'hff;
		for (int i = 0; i < 200 && s[STS_DAC_XFER] !== 1'b0; i++) begin
			rd(OFS_STATUS, s);
		end
	endtask : wait_idle
	task automatic tick(input int gap);
		@(posedge sys_clk);
		pacer_tick <= 1'b1;
		@(posedge sys_clk);
		pacer_tick <= 1'b0;
		repeat (gap) @(posedge sys_clk);
	endtask : tick
	task summarize;
		if (err_total == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	// main sequence
	initial begin
		base = 16'($random(seed));
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'b1;
		wr(OFS_SAMPLE_HI_CFG, 8'h04);
		chk(16'(dac_bipolar), 16'h0001);
		exp_code[0] = 12'h000;
		exp_code[1] = 12'hfff;
		exp_code[2] = 12'($random(seed));
		exp_code[3] = 12'($random(seed));
		for (k = 0; k < 4; k++) begin
			wr(OFS_CODE_LO, exp_code[k][7:0]);
			wr(OFS_CODE_HI, {4'($random(seed)), exp_code[k][11:8]});
			wr(OFS_OUT_SELECT, {k < 3, 5'h00, 2'(k)});
			rd(OFS_STATUS, rb);
			chk(16'(rb[STS_DAC_XFER]), 16'h0001);
			wait_idle();
			if (k < 3) chk(16'(dac_out[k]), 16'h0000);
		end
		for (k = 0; k < 4; k++) chk(16'(dac_out[k]), 16'(exp_code[k]));
		wr(OFS_OUT_SELECT, 8'h01);
		wait_idle();
		chk(16'(dac_out[1]), 16'(exp_code[3]));
		wr(OFS_CHAN_LOW, 8'h00);
		wr(OFS_CHAN_HIGH, 8'h02);
		wr(OFS_TRIGGER, 8'h01);
		repeat (40) @(posedge sys_clk);
		rd_chk(1);
		rd(OFS_SAMPLE_LO, rb);
		chk(16'(rb), 16'h0000);
		wr(OFS_ADC_CTRL, 8'h24);
		wr(OFS_TRIGGER, 8'h01);
		repeat (20) @(posedge sys_clk);
		rd(OFS_STATUS, rb);
		chk(16'(rb[7:6]), 16'h0003);
		repeat (100) @(posedge sys_clk);
		rd(OFS_STATUS, rb);
		chk(16'(rb[7:6]), 16'h0000);
		chk(16'(adc_irq), 16'h0000);
		rd_chk(3);
		wr(OFS_ADC_CTRL, 8'h02);
		k = starts;
		tick(30);
		chk(16'(starts), 16'(k));
		wr(OFS_ADC_CTRL, 8'h13);
		tick(40);
		chk(16'(adc_irq), 16'h0001);
		rd_chk(1);
		wr(OFS_TRIGGER, 8'h02);
		chk(16'(adc_irq), 16'h0000);
		wr(OFS_ADC_CTRL, 8'h17);
		tick(120);
		chk(16'(adc_irq), 16'h0001);
		rd_chk(3);
		wr(OFS_ADC_CTRL, 8'h00);
		@(posedge sys_clk);
		#1;
		chk(16'(adc_irq), 16'h0000);
		// threshold interrupt, single conversions, threshold of two samples
		wr(OFS_THRESH_LO, 8'h02);
		wr(OFS_ADC_CTRL, 8'h33);
		tick(40);
		chk(16'(adc_irq), 16'h0000);
		tick(40);
		chk(16'(adc_irq), 16'h0001);
		rd_chk(2);
		wr(OFS_TRIGGER, 8'h02);
		// threshold interrupt in scan mode, threshold of two whole scans
		wr(OFS_THRESH_LO, 8'h06);
		wr(OFS_ADC_CTRL, 8'h37);
		tick(120);
		chk(16'(adc_irq), 16'h0000);
		tick(120);
		chk(16'(adc_irq), 16'h0001);
		rd_chk(6);
		wr(OFS_TRIGGER, 8'h02);
		// external pin chosen as the trigger source
		wr(OFS_ADC_CTRL, 8'h11);
		@(posedge sys_clk);
		ext_trig <= 1'b1;
		repeat (40) @(posedge sys_clk);
		chk(16'(adc_irq), 16'h0001);
		rd_chk(1);
		ext_trig <= 1'b0;
		summarize();
	end
endmodule : tb_daq_converter_control
